// *** hw/pic_pkg.sv ***
// Package for the priority interrupt controller: register map, field
// positions, source numbering and the link between controller and CPU.
// Assumes one 200 MHz clock shared by both ends.
package pic_pkg;
  localparam int unsigned PIC_AW = 5;
  localparam logic [PIC_AW-1:0] PIC_OFF_PRI_A = 5'h00;
  localparam logic [PIC_AW-1:0] PIC_OFF_PRI_B = 5'h04;
  localparam logic [PIC_AW-1:0] PIC_OFF_PRI_C = 5'h08;
  localparam logic [PIC_AW-1:0] PIC_OFF_PRI_D = 5'h0C;
  localparam logic [PIC_AW-1:0] PIC_OFF_PRI_E = 5'h10;
  localparam logic [PIC_AW-1:0] PIC_OFF_SENSE = 5'h14;
  localparam logic [15:0] PIC_PRI_RESET = 16'h0000;
  localparam logic [15:0] PIC_PRI_E_WMASK = 16'hFFF0;
  localparam logic [15:0] PIC_SENSE_WMASK = 16'h01FF;
  localparam logic [15:0] PIC_SENSE_RESET = 16'h0000;
  localparam int unsigned PIC_NMI_LVL_BIT = 15;
  localparam int unsigned PIC_NMI_EDGE_BIT = 8;
  localparam logic [3:0] PIC_NMI_LEVEL = 4'hF;
  // Source numbering: 8 pins, then module groups in default order
  localparam int unsigned PIC_NEXT = 8;
  localparam int unsigned PIC_NDMA = 4;
  localparam int unsigned PIC_NTMR = 5;
  localparam int unsigned PIC_NSER = 2;
  localparam int unsigned PIC_NSRC = 38;
  // Vector base of the source list; NMI takes its own vector
  localparam logic [7:0] PIC_VEC_NMI = 8'h0B;
  localparam logic [7:0] PIC_VEC_BASE = 8'h40;
  localparam logic [31:0] PIC_RDATA_ZERO = 32'h0000_0000;
  localparam logic [1:0] PIC_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] PIC_HSIZE_WORD = 3'h2;
  typedef enum logic {PIC_HOST_IDLE, PIC_HOST_DATA} pic_host_t;
endpackage

// *** hw/pic_link_if.sv ***
// Link between the interrupt controller and the CPU core.
// Assumes both ends run on hclk.
`timescale 1ns/10ps
interface pic_link_if;
  logic request_out_pin_n;
  logic cpu_request;
  logic [3:0] accepted_level;
  logic [7:0] accepted_vector;
  logic [3:0] cpu_mask_level;
  logic instr_replaced;
  logic mask_updated;
  modport ctrl (output request_out_pin_n, cpu_request, accepted_level,
    accepted_vector, input cpu_mask_level, instr_replaced, mask_updated);
  modport cpu (input request_out_pin_n, cpu_request, accepted_level,
    accepted_vector, output cpu_mask_level, instr_replaced, mask_updated);
endinterface

// *** hw/pic_cpu_end.sv ***
// CPU end of the interrupt link: holds the status-register mask and
// runs a two-step exception sequence, driven by the decode strobe.
// Assumes the controller's link signals are on the same hclk.
`timescale 1ns/10ps
module pic_cpu_end (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Core side
  input wire logic decode_strobe,
  input wire logic return_strobe,
  input wire logic [3:0] return_mask,
  output logic exception_taken,
  output logic [7:0] exception_vector,
  output logic [3:0] status_mask,
  // Link
  pic_link_if.cpu link
);
  import pic_pkg::*;
  logic replace_r;

  // Replace the decoded instruction when a request is pending
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      replace_r <= 1'b0;
      exception_vector <= 8'h00;
    end else begin
      replace_r <= decode_strobe && link.cpu_request && !replace_r;
      if (decode_strobe && link.cpu_request && !replace_r) begin
        exception_vector <= link.accepted_vector;
      end
    end
  end

  // Second step copies the accepted level into the mask; return_strobe loads return_mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_mask <= 4'h0;
      exception_taken <= 1'b0;
    end else begin
      exception_taken <= replace_r;
      if (replace_r) begin
        status_mask <= link.accepted_level;
      end else if (return_strobe) begin
        status_mask <= return_mask;
      end
    end
  end

  assign link.cpu_mask_level = status_mask;
  assign link.instr_replaced = replace_r;
  assign link.mask_updated = exception_taken;
endmodule // pic_cpu_end

// *** hw/pic_ctrl.sv ***
// Priority interrupt controller: AHB-Lite register slave, pin sensing,
// priority selection and the request link towards the CPU.
// Assumes pins are asynchronous; module requests are on hclk.
// Contract
// - Five 16-bit RW priority registers, four fields
// - Fields map pins, DMA, timers, serial, parity, watchdog
// - Field value is level, 0 lowest, 15 highest
// - Shared fields give shared sources equal level
// - Reset clears priorities; standby keeps them
// - Register E bits 3-0 read zero
// - Sense control is 16 bits, reset initialised
// - Bit 15 reads live non-maskable pin level
// - Sense control bits 14-9 read zero
// - Bit 8 picks non-maskable falling or rising edge
// - Bits 7-0 pick pin low-level or falling edge
// - Highest programmed level wins selection
// - Ties resolved by fixed default order
// - Accept only if level above CPU mask; the non-maskable request is accepted at any mask level
// - Accepting drives request-out pin low
// - CPU samples request at next decode
// - CPU pushes status then program counter
// - Accepted level goes into CPU mask
// - Request-out returns high per source kind
// - CPU branches via accepted source vector
// - Edge request latched once, no queueing
// - Level and module requests pend while asserted
`timescale 1ns/10ps
module pic_ctrl (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [pic_pkg::PIC_AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Pins and module requests
  input wire logic nonmaskable_pin,
  input wire logic [7:0] external_request_pins_n,
  input wire logic [3:0] dma_channel_source,
  input wire logic [14:0] timer_channel_source,
  input wire logic [7:0] serial_channel_source,
  input wire logic bus_parity_source,
  input wire logic watchdog_source,
  input wire logic refresh_source,
  // Link
  pic_link_if.ctrl link
);
  import pic_pkg::*;

  logic [15:0] pri_r [5];
  logic [15:0] sense_r;
  logic [2:0] nmi_sync_r;
  logic [7:0] pin_s1_r, pin_s2_r, pin_s3_r;
  logic [7:0] edge_pend_r;
  logic nmi_pend_r;
  logic wr_pend_r;
  logic [PIC_AW-1:0] wr_addr_r;
  logic [7:0] ext_req;
  logic [7:0] ext_fall;
  logic nmi_edge;
  logic [PIC_NSRC-1:0] src_req;
  logic [3:0] src_lvl [PIC_NSRC];
  logic sel_valid;
  logic [3:0] sel_lvl;
  logic [7:0] sel_vec;
  logic sel_nmi;
  logic acc_r, acc_edge_r, acc_nmi_r;
  logic [7:0] acc_vec_r;
  logic [3:0] acc_lvl_r;
  logic [7:0] acc_ext_r;

  // Priority field of register idx at field position f (0 = bits 15-12)
  function automatic logic [3:0] pri_field(input logic [15:0] r,
                                           input int f);
    pri_field = r[15-4*f -: 4];
  endfunction

  // Register index from byte address, five priority words first
  function automatic int reg_index(input logic [PIC_AW-1:0] a);
    reg_index = int'(a[PIC_AW-1:2]);
  endfunction

  // Pin synchronisers; an edge counts once stages two and three differ
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmi_sync_r <= 3'h0;
      pin_s1_r <= 8'hFF;
      pin_s2_r <= 8'hFF;
      pin_s3_r <= 8'hFF;
    end else begin
      nmi_sync_r <= {nmi_sync_r[1:0], nonmaskable_pin};
      pin_s1_r <= external_request_pins_n;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // Sense bit 7 selects pin 0, so the pin order is reversed
  always_comb begin
    for (int i = 0; i < PIC_NEXT; i++) begin
      ext_fall[i] = pin_s3_r[i] && !pin_s2_r[i];
      ext_req[i] = sense_r[7-i] ? edge_pend_r[i] : !pin_s2_r[i];
    end
    nmi_edge = sense_r[PIC_NMI_EDGE_BIT] ?
      (nmi_sync_r[1] && !nmi_sync_r[2]) :
      (!nmi_sync_r[1] && nmi_sync_r[2]);
  end

  // Edge latches: one pending request each; set wins over acceptance
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edge_pend_r <= 8'h00;
      nmi_pend_r <= 1'b0;
    end else begin
      for (int i = 0; i < PIC_NEXT; i++) begin
        if (sense_r[7-i] && ext_fall[i]) begin
          edge_pend_r[i] <= 1'b1;
        end else if (acc_ext_r[i] && link.instr_replaced) begin
          edge_pend_r[i] <= 1'b0;
        end else if (!sense_r[7-i]) begin
          edge_pend_r[i] <= 1'b0;
        end
      end
      if (nmi_edge) begin
        nmi_pend_r <= 1'b1;
      end else if (acc_nmi_r && link.instr_replaced) begin
        nmi_pend_r <= 1'b0;
      end
    end
  end

  // Source list in default order; shared fields give shared levels
  always_comb begin
    src_req = {refresh_source, watchdog_source, bus_parity_source,
      serial_channel_source, timer_channel_source, dma_channel_source,
      ext_req};
    for (int i = 0; i < PIC_NEXT; i++) begin
      src_lvl[i] = pri_field(pri_r[i/4], i%4);
    end
    // Channel pairs 0/1 and 2/3 each read one field
    for (int d = 0; d < PIC_NDMA; d++) begin
      src_lvl[PIC_NEXT+d] = pri_field(pri_r[2], d/2);
    end
    // Timer t owns three requests; timers 0-1 in C, 2-4 in D
    for (int t = 0; t < PIC_NTMR; t++) begin
      for (int k = 0; k < 3; k++) begin
        src_lvl[12+3*t+k] = pri_field(pri_r[2+(t+2)/4], (t+2)%4);
      end
    end
    // Serial channel 0 sits in D, channel 1 in E
    for (int k = 0; k < 4; k++) begin
      src_lvl[27+k] = pri_field(pri_r[3], 3);
      src_lvl[31+k] = pri_field(pri_r[4], 0);
    end
    src_lvl[35] = pri_field(pri_r[4], 1);
    src_lvl[36] = pri_field(pri_r[4], 2);
    src_lvl[37] = pri_field(pri_r[4], 2);
  end

  // Strict greater-than keeps the earliest source on a tie
  always_comb begin
    sel_valid = nmi_pend_r;
    sel_nmi = nmi_pend_r;
    sel_lvl = nmi_pend_r ? PIC_NMI_LEVEL : 4'h0;
    sel_vec = PIC_VEC_NMI;
    for (int s = 0; s < PIC_NSRC; s++) begin
      if (!sel_nmi && src_req[s] && (!sel_valid || src_lvl[s] > sel_lvl))
      begin
        sel_valid = 1'b1;
        sel_lvl = src_lvl[s];
        sel_vec = PIC_VEC_BASE + 8'(s);
      end
    end
  end

  // Acceptance; the pin stays low when a higher request replaces it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_r <= 1'b0;
      acc_edge_r <= 1'b0;
      acc_nmi_r <= 1'b0;
      acc_lvl_r <= 4'h0;
      acc_vec_r <= 8'h00;
      acc_ext_r <= 8'h00;
    end else if (sel_valid && (sel_nmi || sel_lvl > link.cpu_mask_level) &&
                 !link.instr_replaced) begin
      acc_r <= 1'b1;
      acc_lvl_r <= sel_lvl;
      acc_vec_r <= sel_vec;
      acc_nmi_r <= sel_nmi;
      acc_edge_r <= sel_nmi || (sel_vec < PIC_VEC_BASE + 8'(PIC_NEXT) &&
        sense_r[7 - 3'(sel_vec - PIC_VEC_BASE)]);
      for (int i = 0; i < PIC_NEXT; i++) begin
        acc_ext_r[i] <= !sel_nmi && sel_vec == PIC_VEC_BASE + 8'(i);
      end
    end else if (acc_r && ((acc_edge_r && link.instr_replaced) ||
                 (!acc_edge_r && link.mask_updated))) begin
      acc_r <= 1'b0;
      acc_ext_r <= 8'h00;
    end else if (acc_r && !acc_edge_r && !link.mask_updated &&
                 !link.instr_replaced) begin
      acc_r <= 1'b0;
    end
  end

  assign link.request_out_pin_n = !acc_r;
  assign link.cpu_request = acc_r;
  assign link.accepted_level = acc_lvl_r;
  assign link.accepted_vector = acc_vec_r;

  // AHB-Lite: zero wait states, address captured for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end else if (hready) begin
      wr_pend_r <= hsel && htrans[1] && hwrite;
      wr_addr_r <= haddr;
    end
  end

  // Register writes; only standby-proof reset clears them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int r = 0; r < 5; r++) begin
        pri_r[r] <= PIC_PRI_RESET;
      end
      sense_r <= PIC_SENSE_RESET;
    end else if (wr_pend_r) begin
      if (wr_addr_r == PIC_OFF_SENSE) begin
        sense_r <= hwdata[15:0] & PIC_SENSE_WMASK;
      end else if (wr_addr_r == PIC_OFF_PRI_E) begin
        pri_r[4] <= hwdata[15:0] & PIC_PRI_E_WMASK;
      end else if (reg_index(wr_addr_r) < 4) begin
        pri_r[reg_index(wr_addr_r)] <= hwdata[15:0];
      end
    end
  end

  // Read data registered in the address phase; unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= PIC_RDATA_ZERO;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      if (haddr == PIC_OFF_SENSE) begin
        hrdata <= {16'h0000, nmi_sync_r[2], sense_r[14:0]};
      end else if (reg_index(haddr) < 5) begin
        hrdata <= {16'h0000, pri_r[reg_index(haddr)]};
      end else begin
        hrdata <= PIC_RDATA_ZERO;
      end
    end
  end

  // Always ready, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule // pic_ctrl

// *** testbench/pic_link_assertions.sv ***
// Checker for the link between controller and CPU end.
// Assumes every link signal changes on hclk only.
`timescale 1ns/10ps
module pic_link_assertions (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link
  input wire logic request_out_pin_n,
  input wire logic cpu_request,
  input wire logic [3:0] accepted_level,
  input wire logic [7:0] accepted_vector,
  input wire logic [3:0] cpu_mask_level,
  input wire logic instr_replaced,
  input wire logic mask_updated
);
  import pic_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // The non-maskable request bypasses the mask, so it is told apart
  logic nmi;
  assign nmi = (accepted_vector == PIC_VEC_NMI);
  accept_above_mask_a: assert property (
    $rose(cpu_request) && !nmi |-> accepted_level > $past(cpu_mask_level))
    else $error("accepted level not above mask");
  pin_with_request_a: assert property (
    $rose(cpu_request) |-> ##[0:1] !request_out_pin_n)
    else $error("request pin not driven low");
  idle_after_reset_a: assert property (
    $rose(hresetn) |-> request_out_pin_n)
    else $error("request pin low after reset");
  replace_needs_req_a: assert property (
    instr_replaced |-> $past(cpu_request))
    else $error("instruction replaced without request");
  mask_follows_a: assert property (
    instr_replaced |=> mask_updated)
    else $error("mask update missing after replacement");
  mask_takes_level_a: assert property (
    mask_updated |=> cpu_mask_level == $past(accepted_level))
    else $error("mask differs from accepted level");
  pin_release_a: assert property (
    mask_updated |-> ##[0:2]
      (request_out_pin_n || accepted_level > cpu_mask_level))
    else $error("request pin stuck low");
  vector_range_a: assert property (
    !request_out_pin_n |-> nmi || (accepted_vector >= PIC_VEC_BASE &&
      accepted_vector < PIC_VEC_BASE + 8'h28))
    else $error("vector outside the source list");
  nmi_top_level_a: assert property (
    cpu_request && nmi |-> accepted_level == PIC_NMI_LEVEL)
    else $error("non-maskable level wrong");
  // Main scenarios reached
  cover property (instr_replaced);
  cover property ($rose(cpu_request) && nmi);
  cover property (mask_updated && accepted_level == 4'h7);
endmodule // pic_link_assertions

// *** testbench/priority_interrupt_controller_test.sv ***
// Self-checking bench: controller and CPU end joined by the link.
// Assumes word accesses over AHB-Lite and a 200 MHz hclk.
`timescale 1ns/10ps
module priority_interrupt_controller_test;
  import pic_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, dec_stb, ret_stb;
  logic nmi_pin, ref_src, exc_taken, hresp;
  logic [PIC_AW-1:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [7:0] pins_n, exc_vec;
  logic [3:0] dma_src, st_mask;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  pic_link_if link ();
  // Both ends face each other; unused sources stay quiet
  pic_ctrl pic_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .nonmaskable_pin(nmi_pin),
    .external_request_pins_n(pins_n), .dma_channel_source(dma_src),
    .timer_channel_source(15'h0000), .serial_channel_source(8'h00),
    .bus_parity_source(1'b0), .watchdog_source(1'b0),
    .refresh_source(ref_src), .link(link.ctrl));
  pic_cpu_end pic_cpu_end_inst (.hclk(hclk), .hresetn(hresetn),
    .decode_strobe(dec_stb), .return_strobe(ret_stb),
    .return_mask(4'h0), .exception_taken(exc_taken),
    .exception_vector(exc_vec), .status_mask(st_mask), .link(link.cpu));
  pic_link_assertions pic_link_assertions_inst (.hclk(hclk),
    .hresetn(hresetn), .request_out_pin_n(link.request_out_pin_n),
    .cpu_request(link.cpu_request), .accepted_level(link.accepted_level),
    .accepted_vector(link.accepted_vector),
    .cpu_mask_level(link.cpu_mask_level),
    .instr_replaced(link.instr_replaced),
    .mask_updated(link.mask_updated));
  // Clock
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // Hang guard, well above the length of all tests
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One single word transfer; read data lands in rd
  task automatic ahb(input logic w, input logic [PIC_AW-1:0] a,
      input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= PIC_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    hsize <= PIC_HSIZE_WORD;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    check("response", hresp, 1'b0);
  endtask
  task automatic wait_req(output logic seen);
    seen = 1'b0;
    repeat (12) begin
      @(posedge hclk);
      if (link.request_out_pin_n === 1'b0) seen = 1'b1;
    end
  endtask
  // Lets the CPU take the pending request; vector 0 skips that compare
  task automatic take(input logic [7:0] vec, input logic [3:0] lvl);
    logic seen;
    wait_req(seen);
    check("request pin", seen, 1'b1);
    dec_stb <= 1'b1;
    @(posedge hclk);
    dec_stb <= 1'b0;
    seen = 1'b0;
    repeat (8) begin
      @(posedge hclk);
      if (exc_taken === 1'b1 && !seen && vec !== 8'h00)
        check("vector", exc_vec, vec);
      if (exc_taken === 1'b1) seen = 1'b1;
    end
    check("taken", seen, 1'b1);
    check("mask", st_mask, lvl);
  endtask
  // Wait out the pin synchronisers before the mask drops again
  task automatic unmask();
    repeat (5) @(posedge hclk);
    ret_stb <= 1'b1;
    @(posedge hclk);
    ret_stb <= 1'b0;
    @(posedge hclk);
  endtask
  task automatic test_regs();
    logic [31:0] exp;
    for (int i = 0; i < 7; i++) begin
      ahb(1'b0, 5'(i * 4), 32'h0);
      check("reset value", rd, i == 5 ? 32'h0000_8000 : 32'h0);
      ahb(1'b1, 5'(i * 4), 32'hFFFF_FFFF);
      ahb(1'b0, 5'(i * 4), 32'h0);
      exp = i == 4 ? 32'h0000_FFF0 : i == 5 ? 32'h0000_81FF : 32'h0000_FFFF;
      check("read back", rd, i == 6 ? 32'h0 : exp);
      ahb(1'b1, 5'(i * 4), 32'h0);
    end
  endtask
  task automatic test_level();
    logic seen;
    ahb(1'b1, PIC_OFF_PRI_A, 32'h0000_3500);
    pins_n <= 8'hFC;
    take(8'h41, 4'h5);
    pins_n <= 8'hFE;
    wait_req(seen);
    check("masked request", seen, 1'b0);
    pins_n <= 8'hFF;
    unmask();
    wait_req(seen);
    check("withdrawn request", seen, 1'b0);
    pins_n <= 8'hFE;
    take(8'h40, 4'h3);
    pins_n <= 8'hFF;
    unmask();
  endtask
  task automatic test_shared();
    ahb(1'b1, PIC_OFF_PRI_C, 32'h0000_7700);
    dma_src <= 4'b0110;
    take(8'h49, 4'h7);
    dma_src <= 4'h0;
    unmask();
    ahb(1'b1, PIC_OFF_PRI_E, 32'h0000_0060);
    ref_src <= 1'b1;
    take(8'h65, 4'h6);
    ref_src <= 1'b0;
    unmask();
  endtask
  task automatic test_edge();
    logic seen;
    ahb(1'b1, PIC_OFF_PRI_B, 32'h0000_0008);
    ahb(1'b1, PIC_OFF_SENSE, 32'h0000_0001);
    // Two falling edges before the CPU looks
    repeat (2) begin
      pins_n <= 8'h7F;
      repeat (4) @(posedge hclk);
      pins_n <= 8'hFF;
      repeat (4) @(posedge hclk);
    end
    take(8'h47, 4'h8);
    unmask();
    wait_req(seen);
    check("queued edge", seen, 1'b0);
    pins_n <= 8'h7F;
    take(8'h47, 4'h8);
    pins_n <= 8'hFF;
    unmask();
  endtask
  task automatic test_nmi();
    logic seen;
    ahb(1'b1, PIC_OFF_SENSE, 32'h0000_0100);
    nmi_pin <= 1'b0;
    repeat (5) @(posedge hclk);
    ahb(1'b0, PIC_OFF_SENSE, 32'h0);
    check("sense control", rd, 32'h0000_0100);
    wait_req(seen);
    check("falling edge", seen, 1'b0);
    nmi_pin <= 1'b1;
    take(PIC_VEC_NMI, PIC_NMI_LEVEL);
    unmask();
    // Back to the default falling-edge sensing
    ahb(1'b1, PIC_OFF_SENSE, 32'h0000_0000);
    nmi_pin <= 1'b0;
    take(PIC_VEC_NMI, PIC_NMI_LEVEL);
    nmi_pin <= 1'b1;
    unmask();
  endtask
  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = PIC_HSIZE_WORD;
    hwdata = 32'h0;
    dec_stb = 1'b0;
    ret_stb = 1'b0;
    nmi_pin = 1'b1;
    ref_src = 1'b0;
    pins_n = 8'hFF;
    dma_src = 4'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    test_regs();
    $display("registers done");
    test_level();
    $display("level sensing done");
    test_shared();
    $display("shared fields done");
    test_edge();
    $display("edge sensing done");
    test_nmi();
    $display("non-maskable done");
    end_sim();
  end
endmodule // priority_interrupt_controller_test
